// file: hdl/bfspg_guard.sv
// flash self-program guard: lock checks, address latch, interrupt mask, reset vector
//
// Implementation choices: the Wishbone register port and the address map.
`timescale 1ns/100ps
module bfspg_guard
    import bfspg_pkg::*;
#(
    parameter int FLASH_WORD_BITS = 15,
    parameter int PAGE_WORD_BITS  = 7,
    parameter int BOOT_MIN_LOG2   = 8
) (
    // clock and reset
    input  wire logic                            clk,
    input  wire logic                            rstn,
    // wishbone slave
    input  wire bfspg_pkg::bfspg_wb_req_t        wbReq,
    output logic                                 wbAck,
    output logic [31:0]                          wbDatO,
    // cpu side
    input  wire bfspg_pkg::bfspg_cpu_req_t       cpuReq,
    input  wire logic [FLASH_WORD_BITS-1:0]      pcWord,
    input  wire logic                            vectorsInBoot,
    output logic                                 intDisable,
    output logic                                 loadGrant,
    output logic                                 loadDeny,
    output logic                                 storeDeny,
    output logic [15:0]                          resetVector,
    // flash array side
    input  wire logic                            flashDone,
    output logic                                 flashStart,
    output logic [FLASH_WORD_BITS-PAGE_WORD_BITS-1:0] flashPage,
    output logic [PAGE_WORD_BITS-1:0]            flashWord,
    output logic [FLASH_WORD_BITS-1:0]           loadWordAddr,
    output logic                                 loadHighByte,
    // external serial/parallel programming port
    input  wire bfspg_pkg::bfspg_prog_t          prog
);
    import bfspg_pkg::*;

    localparam int FW = FLASH_WORD_BITS;
    localparam int PB = FLASH_WORD_BITS - PAGE_WORD_BITS;

    ////////////////////////////////////////////////////////////////////////////
    // whole state of the block
    typedef struct packed {
        logic                 ack;
        logic [31:0]          rdat;
        logic [LOCK_BITS-1:0] lock;
        logic [FUSE_BITS-1:0] fuse;
        logic                 busy;
        logic [PB-1:0]        page;
        logic [PAGE_WORD_BITS-1:0] word;
        logic                 start;
        logic                 lGrant;
        logic                 lDeny;
        logic                 sDeny;
        logic                 lDenySticky;
        logic                 sDenySticky;
        logic [FW-1:0]        lAddr;
        logic                 lHigh;
        logic                 intOff;
        logic [15:0]          rstVec;
    } bfspg_state_t;

    bfspg_state_t s_q;
    bfspg_state_t s_d;

    ////////////////////////////////////////////////////////////////////////////
    // lock decode and section classification
    logic [1:0]    appField;
    logic [1:0]    bootField;
    logic          appStoreBlk;
    logic          appLoadBlk;
    logic          bootStoreBlk;
    logic          bootLoadBlk;
    logic [15:0]   zPtr;
    logic [FW-1:0] targetWord;
    logic [FW-1:0] bootStart;
    logic          pcInBoot;
    logic          targetInBoot;

    // independent fields, general lock bits take no part in gating
    assign appField   = s_q.lock[LOCK_APP_LSB+1:LOCK_APP_LSB];
    assign bootField  = s_q.lock[LOCK_BOOT_LSB+1:LOCK_BOOT_LSB];
    // pointer pair forms the byte address; word address drops bit zero
    assign zPtr       = {cpuReq.ptrHigh, cpuReq.ptrLow};
    assign targetWord = zPtr[FW:1];

    bfspg_lock_decode u_app_lock (
        .lockField  (appField),
        .storeBlock (appStoreBlk),
        .loadBlock  (appLoadBlk)
    );

    bfspg_lock_decode u_boot_lock (
        .lockField  (bootField),
        .storeBlock (bootStoreBlk),
        .loadBlock  (bootLoadBlk)
    );

    bfspg_section_map #(
        .FLASH_WORD_BITS (FLASH_WORD_BITS),
        .BOOT_MIN_LOG2   (BOOT_MIN_LOG2)
    ) u_section (
        .bootSize     (s_q.fuse[FUSE_SZ_LSB+1:FUSE_SZ_LSB]),
        .pcAddr       (pcWord),
        .targetAddr   (targetWord),
        .bootStart    (bootStart),
        .pcInBoot     (pcInBoot),
        .targetInBoot (targetInBoot)
    );

    ////////////////////////////////////////////////////////////////////////////
    // next-state logic
    logic          wbHit;
    logic          wbWr;
    logic [7:0]    wbAdr;
    logic          storeBlocked;
    logic          loadBlocked;
    logic [FW-1:0] latchedAddr;

    always_comb begin
        s_d          = s_q;
        wbHit        = wbReq.cyc & wbReq.stb & ~s_q.ack;
        wbWr         = wbHit & wbReq.we & wbReq.sel[0];
        wbAdr        = {wbReq.adr[7:ADR_LSB], 2'b00};
        latchedAddr  = {s_q.page, s_q.word};
        s_d.start    = 1'b0;
        s_d.lGrant   = 1'b0;
        s_d.lDeny    = 1'b0;
        s_d.sDeny    = 1'b0;

        // store into a section whose field forbids it
        storeBlocked = targetInBoot ? bootStoreBlk : appStoreBlk;
        // load crossing sections into a read-blocked one
        loadBlocked  = (pcInBoot & ~targetInBoot & appLoadBlk) |
                       (~pcInBoot & targetInBoot & bootLoadBlk);

        // single-cycle registered ack; drops the cycle after it is given
        s_d.ack = wbHit;
        s_d.rdat = RD_ZERO;
        if (wbHit && !wbReq.we) begin
            case (wbAdr)
                ADR_LOCK:   s_d.rdat = 32'(s_q.lock);
                ADR_FUSE:   s_d.rdat = 32'(s_q.fuse);
                ADR_STATUS: begin
                    s_d.rdat[STAT_BUSY_BIT]  = s_q.busy;
                    s_d.rdat[STAT_LDENY_BIT] = s_q.lDenySticky;
                    s_d.rdat[STAT_SDENY_BIT] = s_q.sDenySticky;
                    s_d.rdat[STAT_ADDR_LSB +: FW] = latchedAddr;
                end
                default:    s_d.rdat = RD_ZERO;
            endcase
        end

        // software can only program lock bits, never return them to one
        if (wbWr && wbAdr == ADR_LOCK) begin
            s_d.lock = s_q.lock & wbReq.dat[LOCK_BITS-1:0];
        end
        // fuse register is read-only from the bus side
        // write-one-to-clear of sticky deny flags
        if (wbWr && wbAdr == ADR_STATUS) begin
            if (wbReq.dat[STAT_LDENY_BIT]) begin
                s_d.lDenySticky = 1'b0;
            end
            if (wbReq.dat[STAT_SDENY_BIT]) begin
                s_d.sDenySticky = 1'b0;
            end
        end

        // external programmer: locks program down, chip erase restores all ones
        if (prog.lockWe) begin
            s_d.lock = s_d.lock & prog.lockData;
        end
        if (prog.chipErase) begin
            s_d.lock = LOCK_RESET;
        end
        // fuses change only through the programming port
        if (prog.fuseWe) begin
            s_d.fuse = prog.fuseData;
        end

        // flash completion ends the operation
        if (flashDone) begin
            s_d.busy = 1'b0;
        end

        // program store: boot-resident code only, latch address at start
        if (cpuReq.storeReq) begin
            if (pcInBoot && !storeBlocked && !s_q.busy) begin
                s_d.start = 1'b1;
                s_d.busy  = 1'b1;
                s_d.page  = targetWord[FW-1:PAGE_WORD_BITS];
                s_d.word  = targetWord[PAGE_WORD_BITS-1:0];
            end else begin
                s_d.sDeny       = 1'b1;
                s_d.sDenySticky = 1'b1;
            end
        end

        // program load: byte addressed, bit zero picks the byte
        if (cpuReq.loadReq) begin
            if (loadBlocked) begin
                s_d.lDeny       = 1'b1;
                s_d.lDenySticky = 1'b1;
            end else begin
                s_d.lGrant = 1'b1;
                s_d.lAddr  = targetWord;
                s_d.lHigh  = zPtr[0];
            end
        end

        // interrupt masking while running in a read-protected view
        s_d.intOff = (appLoadBlk & vectorsInBoot & ~pcInBoot) |
                     (bootLoadBlk & ~vectorsInBoot & pcInBoot);

        // reset vector from the fuse, boot start when programmed
        s_d.rstVec = s_q.fuse[FUSE_RST_BIT] ? APP_RESET_VEC
                                            : 16'(bootStart);
    end

    ////////////////////////////////////////////////////////////////////////////
    // state register; nonvolatile bits come up unprogrammed
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            s_q             <= '0;
            s_q.lock        <= LOCK_RESET;
            s_q.fuse        <= FUSE_RESET;
            s_q.rstVec      <= APP_RESET_VEC;
        end else begin
            s_q <= s_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // outputs straight from the state register
    assign wbAck        = s_q.ack;
    assign wbDatO       = s_q.rdat;
    assign intDisable   = s_q.intOff;
    assign loadGrant    = s_q.lGrant;
    assign loadDeny     = s_q.lDeny;
    assign storeDeny    = s_q.sDeny;
    assign resetVector  = s_q.rstVec;
    assign flashStart   = s_q.start;
    // held stable for the whole operation regardless of the pointer
    assign flashPage    = s_q.page;
    assign flashWord    = s_q.word;
    assign loadWordAddr = s_q.lAddr;
    assign loadHighByte = s_q.lHigh;

endmodule

// file: hdl/bfspg_pkg.sv
// shared constants, register map and bus carrier types for the flash self-program guard
package bfspg_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // register map, byte addresses on the wishbone bus
    localparam logic [7:0]  ADR_LOCK        = 8'h00;
    localparam logic [7:0]  ADR_FUSE        = 8'h04;
    localparam logic [7:0]  ADR_STATUS      = 8'h08;
    localparam int          ADR_LSB         = 2;

    // lock register fields, 0 means programmed
    localparam int          LOCK_GEN_LSB    = 0;
    localparam int          LOCK_APP_LSB    = 2;
    localparam int          LOCK_BOOT_LSB   = 4;
    localparam int          LOCK_BITS       = 6;
    localparam logic [5:0]  LOCK_RESET      = 6'h3F;

    // fuse register fields
    localparam int          FUSE_RST_BIT    = 0;
    localparam int          FUSE_SZ_LSB     = 1;
    localparam int          FUSE_BITS       = 3;
    localparam logic [2:0]  FUSE_RESET      = 3'h7;

    // status register fields
    localparam int          STAT_BUSY_BIT   = 0;
    localparam int          STAT_LDENY_BIT  = 1;
    localparam int          STAT_SDENY_BIT  = 2;
    localparam int          STAT_ADDR_LSB   = 16;

    localparam logic [31:0] RD_ZERO         = 32'h0000_0000;
    localparam logic [15:0] APP_RESET_VEC   = 16'h0000;

    ////////////////////////////////////////////////////////////////////////////
    // wishbone request from the master
    typedef struct packed {
        logic        cyc;
        logic        stb;
        logic        we;
        logic [7:0]  adr;
        logic [3:0]  sel;
        logic [31:0] dat;
    } bfspg_wb_req_t;

    // cpu program-memory access request
    typedef struct packed {
        logic        storeReq;
        logic        loadReq;
        logic [7:0]  ptrLow;
        logic [7:0]  ptrHigh;
    } bfspg_cpu_req_t;

    // external programming interface
    typedef struct packed {
        logic        lockWe;
        logic [5:0]  lockData;
        logic        fuseWe;
        logic [2:0]  fuseData;
        logic        chipErase;
    } bfspg_prog_t;

endpackage

// file: hdl/bfspg_lock_decode.sv
// decode of one two-bit section lock field into store and load blocks
`timescale 1ns/100ps
module bfspg_lock_decode (
    // lock field, high bit first, 0 means programmed
    input  wire logic [1:0] lockField,
    // decoded restrictions
    output logic            storeBlock,
    output logic            loadBlock
);
    // 11 free, 10 store blocked, 00 both, 01 load blocked only
    always_comb begin
        storeBlock = ~lockField[0];
        loadBlock  = ~lockField[1];
    end
endmodule

// file: hdl/bfspg_section_map.sv
// classifies two word addresses against the application/boot boundary
`timescale 1ns/100ps
module bfspg_section_map #(
    parameter int FLASH_WORD_BITS = 15,
    parameter int BOOT_MIN_LOG2   = 8
) (
    // boot size configuration, 11 smallest
    input  wire logic [1:0]                 bootSize,
    // addresses to classify
    input  wire logic [FLASH_WORD_BITS-1:0] pcAddr,
    input  wire logic [FLASH_WORD_BITS-1:0] targetAddr,
    // results
    output logic [FLASH_WORD_BITS-1:0]      bootStart,
    output logic                            pcInBoot,
    output logic                            targetInBoot
);
    localparam int SZW = FLASH_WORD_BITS + 1;

    // boot size doubles for each step down of the size field
    function automatic logic [SZW-1:0] bootWords(input logic [1:0] sz);
        logic [SZW-1:0] one;
        one = SZW'(1);
        return one << (BOOT_MIN_LOG2 + 3 - int'(sz));
    endfunction

    function automatic logic inBoot(input logic [FLASH_WORD_BITS-1:0] a,
                                    input logic [FLASH_WORD_BITS-1:0] s);
        return a >= s;
    endfunction

    logic [SZW-1:0] top;

    // boot section sits at the top of flash
    always_comb begin
        top          = SZW'(1) << FLASH_WORD_BITS;
        bootStart    = FLASH_WORD_BITS'(top - bootWords(bootSize));
        pcInBoot     = inBoot(pcAddr, bootStart);
        targetInBoot = inBoot(targetAddr, bootStart);
    end
endmodule

// file: testbench/bfspg_guard_properties.sv
// port assertions for the flash self-program guard
`timescale 1ns/100ps
module bfspg_guard_properties
    import bfspg_pkg::*;
#(
    parameter int FLASH_WORD_BITS = 15,
    parameter int PAGE_WORD_BITS  = 7
) (
    // clock and reset
    input wire logic                                     clk,
    input wire logic                                     rstn,
    // bus and cpu side
    input wire bfspg_pkg::bfspg_wb_req_t                 wbReq,
    input wire logic                                     wbAck,
    input wire bfspg_pkg::bfspg_cpu_req_t                cpuReq,
    input wire logic [FLASH_WORD_BITS-1:0]               pcWord,
    input wire logic                                     vectorsInBoot,
    input wire logic                                     intDisable,
    input wire logic                                     loadGrant,
    input wire logic                                     loadDeny,
    input wire logic                                     storeDeny,
    input wire logic [15:0]                              resetVector,
    // flash side
    input wire logic                                     flashStart,
    input wire logic [FLASH_WORD_BITS-PAGE_WORD_BITS-1:0] flashPage,
    input wire logic [PAGE_WORD_BITS-1:0]                flashWord,
    input wire logic [FLASH_WORD_BITS-1:0]               loadWordAddr,
    input wire logic                                     loadHighByte,
    input wire bfspg_pkg::bfspg_prog_t                   prog
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rstn);
    logic [15:0] expVec_q;
    logic [1:0]  age_q;
    ////////////////////////////////////////////////////////////////////////////
    // shadow of the vector the fuse port asks for; age lets the write land
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            expVec_q <= 16'h0000;
            age_q    <= 2'h0;
        end else if (prog.fuseWe) begin
            expVec_q <= prog.fuseData[0] ? 16'h0000
                      : 16'(17'h0_8000 - (17'h0_0100 << (2'h3 - prog.fuseData[2:1])));
            age_q    <= 2'h0;
        end else if (age_q != 2'h3) begin
            age_q <= age_q + 2'h1;
        end
    end
    ////////////////////////////////////////////////////////////////////////////
    // sequences and properties
    sequence s_wbTake; wbReq.cyc && wbReq.stb && !wbAck; endsequence
    sequence s_loadOk; cpuReq.loadReq ##1 loadGrant; endsequence
    sequence s_storeOk; cpuReq.storeReq ##1 flashStart; endsequence
    property p_ackNext; s_wbTake |=> wbAck; endproperty
    property p_ackPulse; wbAck |=> !wbAck; endproperty
    property p_loadAns; cpuReq.loadReq |=> loadGrant != loadDeny; endproperty
    property p_loadAddr;
        s_loadOk |-> loadHighByte == $past(cpuReq.ptrLow[0])
            && loadWordAddr[6:0] == $past(cpuReq.ptrLow[7:1])
            && loadWordAddr[14:7] == $past(cpuReq.ptrHigh);
    endproperty
    property p_storeAddr;
        s_storeOk |-> flashWord == $past(cpuReq.ptrLow[7:1])
            && flashPage == $past(cpuReq.ptrHigh);
    endproperty
    property p_addrHold; !flashStart |-> $stable(flashPage) && $stable(flashWord); endproperty
    property p_storeApp;
        cpuReq.storeReq && !pcWord[FLASH_WORD_BITS-1] |=> storeDeny && !flashStart;
    endproperty
    property p_intApp;
        !$past(pcWord[FLASH_WORD_BITS-1]) && !$past(vectorsInBoot) |-> !intDisable;
    endproperty
    property p_resetVec; age_q == 2'h3 |-> resetVector == expVec_q; endproperty
    a_ackNext: assert property (p_ackNext) else $error("bus ack missing");
    a_ackPulse: assert property (p_ackPulse) else $error("bus ack too long");
    a_loadAns: assert property (p_loadAns) else $error("load answer wrong");
    a_loadAddr: assert property (p_loadAddr) else $error("load address wrong");
    a_storeAddr: assert property (p_storeAddr) else $error("store target wrong");
    a_addrHold: assert property (p_addrHold) else $error("target moved");
    a_storeApp: assert property (p_storeApp) else $error("app store taken");
    a_intApp: assert property (p_intApp) else $error("mask without cause");
    a_resetVec: assert property (p_resetVec) else $error("reset vector wrong");
endmodule

bind bfspg_guard bfspg_guard_properties #(
    .FLASH_WORD_BITS(FLASH_WORD_BITS), .PAGE_WORD_BITS(PAGE_WORD_BITS)
) bfspg_guard_properties_inst (
    .clk(clk), .rstn(rstn), .wbReq(wbReq), .wbAck(wbAck), .cpuReq(cpuReq),
    .pcWord(pcWord), .vectorsInBoot(vectorsInBoot), .intDisable(intDisable),
    .loadGrant(loadGrant), .loadDeny(loadDeny), .storeDeny(storeDeny),
    .resetVector(resetVector), .flashStart(flashStart), .flashPage(flashPage),
    .flashWord(flashWord), .loadWordAddr(loadWordAddr), .loadHighByte(loadHighByte),
    .prog(prog)
);

// file: testbench/bfspg_flash_model.sv
// flash array stand-in: ends each program operation after a set delay
`timescale 1ns/100ps
module bfspg_flash_model (
    // clock and reset
    input  wire logic       clk,
    input  wire logic       rstn,
    // guard side
    input  wire logic       flashStart,
    input  wire logic [7:0] latency,
    output logic            flashDone
);
    logic [7:0] left_q;
    ////////////////////////////////////////////////////////////////////////////
    // count busy time down; latency input lets the bench be prompt or slow
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            left_q    <= 8'h00;
            flashDone <= 1'b0;
        end else begin
            flashDone <= (left_q == 8'h01);
            if (flashStart) begin
                left_q <= latency;
            end else if (left_q != 8'h00) begin
                left_q <= left_q - 8'h01;
            end
        end
    end
endmodule

// file: testbench/bfspg_guard_tb.sv
// self-checking bench for the flash self-program guard
`timescale 1ns/100ps
module bfspg_guard_tb;
    import bfspg_pkg::*;
    localparam logic [14:0] BOOT_PC  = 15'h7F80;
    localparam logic [14:0] APP_PC   = 15'h0040;
    localparam logic [15:0] APP_PTR  = 16'h0247;
    localparam logic [15:0] BOOT_PTR = 16'hFE21;
    logic           clk, rstn, wbAck, intDisable, loadGrant, loadDeny, storeDeny;
    logic           flashDone, flashStart, loadHighByte, vectorsInBoot;
    logic [31:0]    wbDatO, rd;
    logic [15:0]    resetVector;
    logic [14:0]    pcWord, loadWordAddr;
    logic [7:0]     flashPage, flashLat;
    logic [6:0]     flashWord;
    bfspg_wb_req_t  wbReq;
    bfspg_cpu_req_t cpuReq;
    bfspg_prog_t    prog;
    int             n_mismatch, total_checks;
    ////////////////////////////////////////////////////////////////////////////
    bfspg_guard bfspg_guard_inst (
        .clk(clk), .rstn(rstn), .wbReq(wbReq), .wbAck(wbAck), .wbDatO(wbDatO),
        .cpuReq(cpuReq), .pcWord(pcWord), .vectorsInBoot(vectorsInBoot),
        .intDisable(intDisable), .loadGrant(loadGrant), .loadDeny(loadDeny),
        .storeDeny(storeDeny), .resetVector(resetVector), .flashDone(flashDone),
        .flashStart(flashStart), .flashPage(flashPage), .flashWord(flashWord),
        .loadWordAddr(loadWordAddr), .loadHighByte(loadHighByte), .prog(prog));
    bfspg_flash_model bfspg_flash_model_inst (.clk(clk), .rstn(rstn),
        .flashStart(flashStart), .latency(flashLat), .flashDone(flashDone));
    // 40 MHz clock
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    ////////////////////////////////////////////////////////////////////////////
    task automatic chk(input string what, input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic print_verdict;
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    // one classic bus cycle; read data lands in rd
    task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] dat);
        int n;
        @(posedge clk);
        wbReq <= {2'h3, we, adr, 4'hF, dat};
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (wbAck !== 1'b1 && n < 16);
        rd = wbDatO;
        wbReq <= '0;
        if (wbAck !== 1'b1) begin
            n_mismatch++;
            print_verdict();
        end
    endtask
    // one store or load pulse; the pointer moves away right after it is taken
    task automatic op(input logic st, input logic [14:0] pc, input logic [15:0] ptr,
                      input logic ok);
        int n;
        @(posedge clk);
        pcWord <= pc;
        cpuReq <= {st, !st, ptr[7:0], ptr[15:8]};
        @(posedge clk);
        cpuReq <= {2'h0, ~ptr[7:0], ~ptr[15:8]};
        #1;
        if (st) begin
            chk("start", flashStart, ok);
            chk("sdeny", storeDeny, !ok);
            if (ok) begin
                chk("target", {flashPage, flashWord}, ptr[15:1]);
                n = 0;
                while (flashDone !== 1'b1 && n < 64) begin
                    @(posedge clk);
                    n++;
                end
                if (flashDone !== 1'b1) begin
                    n_mismatch++;
                    print_verdict();
                end
                #1;
                chk("held", {flashPage, flashWord}, ptr[15:1]);
            end
        end else begin
            chk("grant", loadGrant, ok);
            chk("ldeny", loadDeny, !ok);
            if (ok)
                chk("laddr", {loadWordAddr, loadHighByte}, ptr);
        end
    endtask
    task automatic irq(input logic [14:0] pc, input logic vib, input logic exp);
        @(posedge clk);
        pcWord <= pc;
        vectorsInBoot <= vib;
        repeat (2) @(posedge clk);
        #1;
        chk("mask", intDisable, exp);
    endtask
    // programmer port pulse
    task automatic pg(input logic [11:0] v);
        @(posedge clk);
        prog <= v;
        @(posedge clk);
        prog <= '0;
    endtask
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        logic [5:0] lk;
        rstn = 1'b0;
        wbReq = '0;
        cpuReq = '0;
        prog = '0;
        pcWord = BOOT_PC;
        vectorsInBoot = 1'b0;
        flashLat = 8'h02;
        n_mismatch = 0;
        total_checks = 0;
        repeat (8) @(posedge clk);
        rstn <= 1'b1;
        // reset values and an unmapped place
        wb(1'b0, ADR_LOCK, RD_ZERO);
        chk("lock", rd, 32'h0000_003F);
        wb(1'b0, ADR_FUSE, RD_ZERO);
        chk("fuse", rd, 32'h0000_0007);
        wb(1'b0, ADR_STATUS, RD_ZERO);
        chk("status", rd, RD_ZERO);
        wb(1'b0, 8'h0C, RD_ZERO);
        chk("unmapped", rd, RD_ZERO);
        chk("rvec", resetVector, APP_RESET_VEC);
        // general lock bits programmed: neither stores nor loads care
        wb(1'b1, ADR_LOCK, 32'h0000_003C);
        op(1'b1, BOOT_PC, APP_PTR, 1'b1);
        op(1'b0, BOOT_PC, APP_PTR, 1'b1);
        op(1'b1, APP_PC, APP_PTR, 1'b0);
        // refused store leaves its sticky flag; latched target is the last granted one
        wb(1'b0, ADR_STATUS, RD_ZERO);
        chk("stsdeny", rd, 32'h0123_0004);
        wb(1'b1, ADR_STATUS, 32'h0000_0004);
        wb(1'b0, ADR_STATUS, RD_ZERO);
        chk("stsclr", rd, 32'h0123_0000);
        // every pattern of each field; the other section stays open
        for (int f = 0; f < 2; f++) begin
            for (int p = 0; p < 4; p++) begin
                pg(12'h001);
                lk = f ? {p[1:0], 4'hF} : {2'h3, p[1:0], 2'h3};
                wb(1'b1, ADR_LOCK, {26'h0, lk});
                wb(1'b0, ADR_LOCK, RD_ZERO);
                chk("lockrd", rd, {26'h0, lk});
                op(1'b1, BOOT_PC, f ? BOOT_PTR : APP_PTR, p[0]);
                op(1'b0, f ? APP_PC : BOOT_PC, f ? BOOT_PTR : APP_PTR, p[1]);
                op(1'b0, f ? BOOT_PC : APP_PC, f ? APP_PTR : BOOT_PTR, 1'b1);
                irq(f ? BOOT_PC : APP_PC, !f, !p[1]);
            end
            flashLat <= 8'h14;
        end
        // lock bits only clear from software or programmer; erase sets them
        wb(1'b1, ADR_LOCK, 32'h0000_0037);
        wb(1'b1, ADR_LOCK, 32'h0000_003F);
        pg({1'h1, 6'h1F, 5'h00});
        wb(1'b0, ADR_LOCK, RD_ZERO);
        chk("noclear", rd, 32'h0000_0017);
        pg(12'h001);
        wb(1'b0, ADR_LOCK, RD_ZERO);
        chk("erase", rd, 32'h0000_003F);
        // fuses move only from the programmer port
        wb(1'b1, ADR_FUSE, RD_ZERO);
        pg(12'h01C);
        wb(1'b0, ADR_FUSE, RD_ZERO);
        chk("fusewr", rd, 32'h0000_0006);
        chk("rvecboot", resetVector, 16'h7F00);
        pg(12'h010);
        op(1'b1, 15'h7800, APP_PTR, 1'b1);
        op(1'b1, 15'h77FF, APP_PTR, 1'b0);
        chk("rvecbig", resetVector, 16'h7800);
        print_verdict();
    end
endmodule
